// file: rtl/edtc_regs.vh
// Constants for the eight-bit dual-compare timer: field positions, reset values, mode codes.
// Assumes inclusion by the timer core and its compare channel only.
`ifndef EDTC_REGS_VH
`define EDTC_REGS_VH

// Counter range
`define EDTC_BOTTOM        8'h00
`define EDTC_MAX           8'hff

// Waveform mode codes
`define EDTC_WGM_NORMAL    3'h0
`define EDTC_WGM_PCPWM_MAX 3'h1
`define EDTC_WGM_CTC       3'h2
`define EDTC_WGM_FPWM_MAX  3'h3
`define EDTC_WGM_PCPWM_OCA 3'h5
`define EDTC_WGM_FPWM_OCA  3'h7

// Clock source select codes
`define EDTC_CS_STOP       3'h0
`define EDTC_CS_EXT_FALL   3'h6
`define EDTC_CS_EXT_RISE   3'h7

// Flag and mask bit positions
`define EDTC_BIT_OVF       0
`define EDTC_BIT_MATCH_A   1
`define EDTC_BIT_MATCH_B   2

// Reset values
`define EDTC_RST_COUNT     8'h00
`define EDTC_RST_COMPARE   8'h00
`define EDTC_RST_CTRL      3'h0
`define EDTC_RST_ACTION    2'h0
`define EDTC_RST_FLAGS     3'h0

`endif

// file: rtl/edtc_compare.v
// One output compare channel: double-buffered compare value, match detect, waveform state.
// Assumes the timer core supplies tick, counter, top/bottom and the mode decode on mclk_in.
`timescale 1ns/1ps
`default_nettype none
`include "edtc_regs.vh"

module edtc_compare #(
	parameter WIDTH = 8
) (
	// Clock, reset, enable
	input  wire             mclk_in,
	input  wire             reset_in,
	input  wire             clk_en_in,
	// Timer state
	input  wire             tick_in,
	input  wire [WIDTH-1:0] count_in,
	input  wire             at_top_in,
	input  wire             at_bottom_in,
	input  wire             pwm_mode_in,
	input  wire             fast_pwm_in,
	input  wire             phase_pwm_in,
	input  wire             up_in,
	input  wire             block_in,
	// Software access
	input  wire             cmp_we_in,
	input  wire [WIDTH-1:0] cmp_wdata_in,
	input  wire [1:0]       action_in,
	input  wire             force_in,
	// Results
	output wire [WIDTH-1:0] cmp_active_out,
	output wire [WIDTH-1:0] cmp_visible_out,
	output wire             match_out,
	output reg              wave_out
);

	reg  [WIDTH-1:0] buf_reg;
	reg  [WIDTH-1:0] active_reg;
	reg              wave_next;

	assign cmp_active_out  = active_reg;
	assign cmp_visible_out = pwm_mode_in ? buf_reg : active_reg;
	// Continuous equality, gated off after a counter write until the next tick has gone by
	assign match_out       = (count_in == active_reg) && !block_in;

	// Buffer takes software writes while buffering; active copies at the sequence edge
	always @(posedge mclk_in) begin
		if (reset_in) begin
			buf_reg    <= `EDTC_RST_COMPARE;
			active_reg <= `EDTC_RST_COMPARE;
		end else if (clk_en_in) begin
			if (cmp_we_in)
				buf_reg <= cmp_wdata_in;
			if (!pwm_mode_in) begin
				if (cmp_we_in)
					active_reg <= cmp_wdata_in;
			end else if (tick_in && ((fast_pwm_in && at_top_in) || (phase_pwm_in && at_top_in))) begin
				active_reg <= buf_reg;
			end
		end
	end

	// Waveform state: action bits read live, never buffered
	always @* begin
		wave_next = wave_out;
		if (!pwm_mode_in) begin
			if ((tick_in && match_out) || force_in) begin
				case (action_in)
					2'h1:    wave_next = ~wave_out;
					2'h2:    wave_next = 1'b0;
					2'h3:    wave_next = 1'b1;
					default: wave_next = wave_out;
				endcase
			end
		end else if (tick_in && action_in[1]) begin
			if (fast_pwm_in) begin
				if (match_out)
					wave_next = action_in[0];
				else if (at_top_in)
					wave_next = ~action_in[0]; // Level at the bottom that follows top
			end else if (match_out) begin
				wave_next = up_in ? action_in[0] : ~action_in[0];
			end
		end
	end

	// Mode changes touch only the counting path, so state carries over
	always @(posedge mclk_in) begin
		if (reset_in)
			wave_out <= 1'b0;
		else if (clk_en_in)
			wave_out <= wave_next;
	end

endmodule // edtc_compare

`default_nettype wire

// file: rtl/edtc_timer.v
// Eight-bit timer/counter with two compare channels, counter unit and clock-select front end.
// Assumes a prescaler supplies one-cycle tap pulses on mclk_in and software reaches fields as plain ports.
//
// Summary of operation
// - Counter and both compare values are eight bits wide.
// - Overflow, match A, match B flags each visible and individually maskable.
// - Tick comes from system clock, prescaler or external pin; clock select zero stops counting.
// - Counter is readable and writable whether or not the tick runs.
// - A software counter write beats any clear, increment or decrement.
// - Each tick clears, increments or decrements the counter per mode.
// - Three-bit waveform mode, low two bits in control A, top in control B.
// - Floor 0x00, ceiling 0xff; top is ceiling or compare value A.
// - Counter compared continuously against both compare values.
// - A match sets its flag on the following tick.
// - A set match flag with its mask bit raises an interrupt request.
// - Match flags clear on service or on a written one.
// - Overflow flag set per waveform mode and can raise a request.
// - Compare values double buffered in PWM modes, direct otherwise.
// - Buffered value copied to active only at top.
// - Software compare writes reach buffer when buffering, else active register.
// - Force strobe updates waveform in non-PWM modes, no flag, no clear.
// - A counter write blocks all compare matches in the next tick.
// - Waveform states survive waveform mode changes.
// - Output action bits take effect immediately, not buffered.
// - Normal mode wraps 0xff to 0x00, overflow flag set as zero reached.
// - Clear-on-match mode clears the counter when it equals compare value A.
// - Fast PWM, modes 3 and 7, single slope; top ceiling or A.
// - Reset clears the waveform state registers.
`timescale 1ns/1ps
`default_nettype none
`include "edtc_regs.vh"

module edtc_timer #(
	parameter WIDTH = 8
) (
	// Clock, reset, enable
	input  wire             mclk_in,
	input  wire             reset_in,
	input  wire             clk_en_in,
	// Tick sources
	input  wire [4:0]       prescale_tap_in,
	input  wire             external_count_input_in,
	// Control fields
	input  wire [1:0]       waveform_mode_low_in,
	input  wire             waveform_mode_high_in,
	input  wire             ctrl_we_in,
	input  wire [2:0]       clock_source_select_in,
	input  wire [1:0]       action_a_in,
	input  wire [1:0]       action_b_in,
	input  wire             force_match_strobe_a_in,
	input  wire             force_match_strobe_b_in,
	// Counter and compare access
	input  wire             counter_we_in,
	input  wire [WIDTH-1:0] counter_wdata_in,
	input  wire             compare_a_we_in,
	input  wire             compare_b_we_in,
	input  wire [WIDTH-1:0] compare_wdata_in,
	// Flags and mask
	input  wire             flag_we_in,
	input  wire [2:0]       flag_wdata_in,
	input  wire [2:0]       irq_ack_in,
	input  wire             mask_we_in,
	input  wire [2:0]       mask_wdata_in,
	// Status
	output reg  [WIDTH-1:0] counter_value_out,
	output wire [WIDTH-1:0] compare_value_a_out,
	output wire [WIDTH-1:0] compare_value_b_out,
	output reg  [2:0]       timer_flag_reg_out,
	output reg  [2:0]       timer_mask_reg_out,
	output wire [2:0]       irq_req_out,
	output wire [2:0]       waveform_mode_out,
	output wire [2:0]       clock_source_select_out,
	output wire [1:0]       action_a_out,
	output wire [1:0]       action_b_out,
	// Waveform side
	output wire             waveform_out_a_out,
	output wire             waveform_out_b_out,
	output wire             match_a_out,
	output wire             match_b_out,
	output wire             at_top_out,
	output wire             at_bottom_out
);

	// Control registers
	reg  [2:0]       wgm_reg;
	reg  [2:0]       cs_reg;
	reg  [1:0]       act_a_reg;
	reg  [1:0]       act_b_reg;
	// Counter unit
	reg  [WIDTH-1:0] count_next;
	reg              down_reg;
	reg              down_next;
	reg              block_reg;
	reg  [2:0]       flag_next;
	// External pin synchroniser and edge detect
	reg              ext_meta_reg;
	reg              ext_sync_reg;
	reg              ext_prev_reg;
	reg              tick;

	wire [WIDTH-1:0] cmp_a_active;
	wire             match_a;
	wire             match_b;
	wire [WIDTH-1:0] top_value;
	wire             fast_pwm;
	wire             phase_pwm;
	wire             pwm_mode;
	wire             top_is_a;
	wire             at_top;
	wire             at_bottom;
	wire             ext_rise;
	wire             ext_fall;

	// True for every waveform code in which the counter stops at compare value A
	function top_from_a;
		input [2:0] mode;
		begin
			top_from_a = (mode == `EDTC_WGM_CTC) || (mode == `EDTC_WGM_PCPWM_OCA) ||
			             (mode == `EDTC_WGM_FPWM_OCA);
		end
	endfunction

	assign waveform_mode_out       = wgm_reg;
	assign clock_source_select_out = cs_reg;
	assign action_a_out            = act_a_reg;
	assign action_b_out            = act_b_reg;

	// Mode decode
	assign fast_pwm  = (wgm_reg[1:0] == 2'h3);
	assign phase_pwm = (wgm_reg[1:0] == 2'h1);
	assign pwm_mode  = fast_pwm || phase_pwm;
	assign top_is_a  = top_from_a(wgm_reg);
	assign top_value = top_is_a ? cmp_a_active : `EDTC_MAX;
	assign at_top    = (counter_value_out == top_value);
	assign at_bottom = (counter_value_out == `EDTC_BOTTOM);
	assign at_top_out    = at_top;
	assign at_bottom_out = at_bottom;

	// Control fields: waveform mode joins its high and low input fields; all fields load on one strobe
	always @(posedge mclk_in) begin
		if (reset_in) begin
			wgm_reg   <= `EDTC_RST_CTRL;
			cs_reg    <= `EDTC_RST_CTRL;
			act_a_reg <= `EDTC_RST_ACTION;
			act_b_reg <= `EDTC_RST_ACTION;
		end else if (clk_en_in && ctrl_we_in) begin
			wgm_reg   <= {waveform_mode_high_in, waveform_mode_low_in};
			cs_reg    <= clock_source_select_in;
			act_a_reg <= action_a_in;
			act_b_reg <= action_b_in;
		end
	end

	// Pin passes two flops before the edge detector; the detector compares the second with a third
	always @(posedge mclk_in) begin
		if (reset_in) begin
			ext_meta_reg <= 1'b0;
			ext_sync_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
		end else if (clk_en_in) begin
			ext_meta_reg <= external_count_input_in;
			ext_sync_reg <= ext_meta_reg;
			ext_prev_reg <= ext_sync_reg;
		end
	end

	assign ext_rise = ext_sync_reg && !ext_prev_reg;
	assign ext_fall = !ext_sync_reg && ext_prev_reg;

	// Clock select: code 1 runs at the system rate, 2..5 use prescaler taps
	always @* begin
		case (cs_reg)
			`EDTC_CS_STOP:     tick = 1'b0;
			3'h1:              tick = 1'b1;
			3'h2:              tick = prescale_tap_in[1];
			3'h3:              tick = prescale_tap_in[2];
			3'h4:              tick = prescale_tap_in[3];
			3'h5:              tick = prescale_tap_in[4];
			`EDTC_CS_EXT_FALL: tick = ext_fall;
			`EDTC_CS_EXT_RISE: tick = ext_rise;
			default:           tick = 1'b0;
		endcase
	end

	// Counter sequence per mode
	always @* begin
		count_next = counter_value_out;
		down_next  = down_reg;
		if (tick) begin
			if (phase_pwm) begin
				if (at_top && !down_reg) begin
					down_next  = 1'b1;
					count_next = counter_value_out - 8'h01;
				end else if (at_bottom && down_reg) begin
					down_next  = 1'b0;
					count_next = counter_value_out + 8'h01;
				end else if (down_reg) begin
					count_next = counter_value_out - 8'h01;
				end else begin
					count_next = counter_value_out + 8'h01;
				end
			end else begin
				down_next = 1'b0;
				if (top_is_a && at_top)
					count_next = `EDTC_BOTTOM;
				else
					count_next = counter_value_out + 8'h01;
			end
		end
		if (counter_we_in)
			count_next = counter_wdata_in;
	end

	// Counter register, direction and match blocking
	always @(posedge mclk_in) begin
		if (reset_in) begin
			counter_value_out <= `EDTC_RST_COUNT;
			down_reg          <= 1'b0;
			block_reg         <= 1'b0;
		end else if (clk_en_in) begin
			counter_value_out <= count_next;
			down_reg          <= down_next;
			// Block holds until the next tick has gone by, even while stopped
			if (counter_we_in)
				block_reg <= 1'b1;
			else if (tick)
				block_reg <= 1'b0;
		end
	end

	// Flags: hardware set wins over software or service clear
	always @* begin
		flag_next = timer_flag_reg_out;
		if (flag_we_in)
			flag_next = flag_next & ~flag_wdata_in;
		flag_next = flag_next & ~irq_ack_in;
		if (tick) begin
			// Overflow: wrap at max, or top in fast PWM, or bottom in phase-correct
			if ((!pwm_mode && counter_value_out == `EDTC_MAX && !(top_is_a && at_top)) ||
			    (fast_pwm && at_top) || (phase_pwm && at_bottom && down_reg))
				flag_next[`EDTC_BIT_OVF] = 1'b1;
			if (match_a)
				flag_next[`EDTC_BIT_MATCH_A] = 1'b1;
			if (match_b)
				flag_next[`EDTC_BIT_MATCH_B] = 1'b1;
		end
	end

	// Flag and mask registers
	always @(posedge mclk_in) begin
		if (reset_in) begin
			timer_flag_reg_out <= `EDTC_RST_FLAGS;
			timer_mask_reg_out <= `EDTC_RST_FLAGS;
		end else if (clk_en_in) begin
			timer_flag_reg_out <= flag_next;
			if (mask_we_in)
				timer_mask_reg_out <= mask_wdata_in;
		end
	end

	// Requests: flag gated by its mask
	assign irq_req_out = timer_flag_reg_out & timer_mask_reg_out;

	assign match_a_out = match_a;
	assign match_b_out = match_b;

	// Channel A: also supplies the top value
	edtc_compare #(
		.WIDTH(WIDTH)
	) u_cmp_a (
		.mclk_in         (mclk_in),
		.reset_in        (reset_in),
		.clk_en_in       (clk_en_in),
		.tick_in         (tick),
		.count_in        (counter_value_out),
		.at_top_in       (at_top),
		.at_bottom_in    (at_bottom),
		.pwm_mode_in     (pwm_mode),
		.fast_pwm_in     (fast_pwm),
		.phase_pwm_in    (phase_pwm),
		.up_in           (!down_reg),
		.block_in        (block_reg),
		.cmp_we_in       (compare_a_we_in),
		.cmp_wdata_in    (compare_wdata_in),
		.action_in       (act_a_reg),
		.force_in        (force_match_strobe_a_in),
		.cmp_active_out  (cmp_a_active),
		.cmp_visible_out (compare_value_a_out),
		.match_out       (match_a),
		.wave_out        (waveform_out_a_out)
	);

	// Channel B
	edtc_compare #(
		.WIDTH(WIDTH)
	) u_cmp_b (
		.mclk_in         (mclk_in),
		.reset_in        (reset_in),
		.clk_en_in       (clk_en_in),
		.tick_in         (tick),
		.count_in        (counter_value_out),
		.at_top_in       (at_top),
		.at_bottom_in    (at_bottom),
		.pwm_mode_in     (pwm_mode),
		.fast_pwm_in     (fast_pwm),
		.phase_pwm_in    (phase_pwm),
		.up_in           (!down_reg),
		.block_in        (block_reg),
		.cmp_we_in       (compare_b_we_in),
		.cmp_wdata_in    (compare_wdata_in),
		.action_in       (act_b_reg),
		.force_in        (force_match_strobe_b_in),
		.cmp_active_out  (),
		.cmp_visible_out (compare_value_b_out),
		.match_out       (match_b),
		.wave_out        (waveform_out_b_out)
	);

endmodule // edtc_timer

`default_nettype wire

// file: tb/edtc_timer_asserts.sv
// Concurrent checks for the eight-bit dual-compare timer, attached to its top by bind.
// Assumes only the top's ports, one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module edtc_timer_chk #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input wire logic             mclk_in,
	input wire logic             reset_in,
	// Software side
	input wire logic             clk_en_in,
	input wire logic             counter_we_in,
	input wire logic [WIDTH-1:0] counter_wdata_in,
	input wire logic             force_match_strobe_a_in,
	input wire logic             flag_we_in,
	input wire logic [2:0]       irq_ack_in,
	// Status and waveform
	input wire logic [WIDTH-1:0] counter_value_out,
	input wire logic [WIDTH-1:0] compare_value_a_out,
	input wire logic [2:0]       timer_flag_reg_out,
	input wire logic [2:0]       timer_mask_reg_out,
	input wire logic [2:0]       irq_req_out,
	input wire logic [2:0]       waveform_mode_out,
	input wire logic [2:0]       clock_source_select_out,
	input wire logic [1:0]       action_a_out,
	input wire logic             waveform_out_a_out,
	input wire logic             match_a_out,
	input wire logic             match_b_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (reset_in);
	// No software disturbance of the counter this cycle
	wire quiet = clk_en_in && !counter_we_in;
	wire calm  = !flag_we_in && irq_ack_in == 3'h0;
	// Ticking every cycle in a settled mode; mode and select held two cycles since the tick may be registered
	sequence run1(m);
		waveform_mode_out == m && $past(waveform_mode_out) == m && clock_source_select_out == 3'h1 &&
			$past(clock_source_select_out) == 3'h1 && quiet;
	endsequence
	AST_IRQ_MASK: assert property (irq_req_out == (timer_flag_reg_out & timer_mask_reg_out))
		else $error("interrupt request differs from flag and mask");
	AST_CNT_WRITE: assert property (clk_en_in && counter_we_in |=> counter_value_out == $past(counter_wdata_in))
		else $error("counter write lost");
	AST_WRITE_BLOCKS: assert property (clk_en_in && counter_we_in |=> !match_a_out && !match_b_out)
		else $error("match seen right after counter write");
	AST_STOPPED: assert property (clock_source_select_out == 3'h0 && $past(clock_source_select_out) == 3'h0 && quiet
		|=> $stable(counter_value_out)) else $error("stopped counter moved");
	AST_NORMAL_INC: assert property (run1(3'h0) |=> counter_value_out == $past(counter_value_out) + 8'h01)
		else $error("normal mode did not increment");
	AST_OVERFLOW: assert property (run1(3'h0) && counter_value_out == 8'hff
		|=> counter_value_out == 8'h00 && timer_flag_reg_out[0]) else $error("overflow not flagged at wrap");
	AST_CTC_CLEAR: assert property (run1(3'h2) && match_a_out |=> counter_value_out == 8'h00)
		else $error("clear on match missing");
	AST_MATCH_FLAG: assert property (run1(3'h0) && match_a_out && calm ##1 clk_en_in && calm
		|-> ##[0:1] timer_flag_reg_out[1]) else $error("match flag not set");
	AST_FORCE: assert property (force_match_strobe_a_in && quiet && calm && clock_source_select_out == 3'h0 &&
		$past(clock_source_select_out) == 3'h0 && waveform_mode_out == 3'h0 && action_a_out == 2'h1
		|=> ##1 waveform_out_a_out != $past(waveform_out_a_out, 2) && timer_flag_reg_out == $past(timer_flag_reg_out, 2))
		else $error("force strobe misbehaved");
	AST_RESET: assert property (disable iff (1'b0) reset_in |=> counter_value_out == 8'h00 &&
		compare_value_a_out == 8'h00 && timer_flag_reg_out == 3'h0 && timer_mask_reg_out == 3'h0 &&
		clock_source_select_out == 3'h0 && !waveform_out_a_out) else $error("state not cleared by reset");
	// Main scenarios reached
	CV_CTC: cover property (run1(3'h2) && match_a_out);
	CV_WRAP: cover property (run1(3'h0) && counter_value_out == 8'hff);
	CV_FORCE: cover property (force_match_strobe_a_in && clock_source_select_out == 3'h0);
endmodule // edtc_timer_chk

bind edtc_timer edtc_timer_chk #(.WIDTH(WIDTH)) u_chk (.mclk_in(mclk_in), .reset_in(reset_in),
	.clk_en_in(clk_en_in), .counter_we_in(counter_we_in), .counter_wdata_in(counter_wdata_in),
	.force_match_strobe_a_in(force_match_strobe_a_in), .flag_we_in(flag_we_in), .irq_ack_in(irq_ack_in),
	.counter_value_out(counter_value_out), .compare_value_a_out(compare_value_a_out),
	.timer_flag_reg_out(timer_flag_reg_out), .timer_mask_reg_out(timer_mask_reg_out), .irq_req_out(irq_req_out),
	.waveform_mode_out(waveform_mode_out), .clock_source_select_out(clock_source_select_out),
	.action_a_out(action_a_out), .waveform_out_a_out(waveform_out_a_out), .match_a_out(match_a_out),
	.match_b_out(match_b_out));
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the eight-bit dual-compare timer: one task per scenario.
// Assumes the timer top and its include path; inputs change on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int K_CNT = 0, K_CMPA = 1, K_CMPB = 2, K_FLAG = 3, K_MASK = 4, K_ACK = 5, K_FORCE = 6;
	// Design inputs, all defined at time zero
	logic       mclk_in = 1'b0, reset_in = 1'b1, clk_en_in = 1'b1, ctrl_we_in = 1'b0;
	logic [1:0] waveform_mode_low_in = 2'h0, action_a_in = 2'h0;
	logic       waveform_mode_high_in = 1'b0, counter_we_in = 1'b0, compare_a_we_in = 1'b0;
	logic       compare_b_we_in = 1'b0, flag_we_in = 1'b0, mask_we_in = 1'b0, force_match_strobe_a_in = 1'b0;
	logic [2:0] clock_source_select_in = 3'h0, flag_wdata_in = 3'h0, mask_wdata_in = 3'h0, irq_ack_in = 3'h0;
	logic [7:0] counter_wdata_in = 8'h00, compare_wdata_in = 8'h00;
	// Design outputs
	wire  [7:0] counter_value_out, compare_value_a_out;
	wire  [2:0] timer_flag_reg_out, timer_mask_reg_out, irq_req_out, waveform_mode_out, clock_source_select_out;
	wire        waveform_out_a_out, waveform_out_b_out, match_a_out, match_b_out;
	int         errors = 0, n_checks = 0, cycles = 0;

	edtc_timer DUT (.mclk_in(mclk_in), .reset_in(reset_in), .clk_en_in(clk_en_in), .prescale_tap_in(5'h00),
		.external_count_input_in(1'b0), .waveform_mode_low_in(waveform_mode_low_in),
		.waveform_mode_high_in(waveform_mode_high_in), .ctrl_we_in(ctrl_we_in),
		.clock_source_select_in(clock_source_select_in), .action_a_in(action_a_in), .action_b_in(2'h0),
		.force_match_strobe_a_in(force_match_strobe_a_in), .force_match_strobe_b_in(1'b0),
		.counter_we_in(counter_we_in), .counter_wdata_in(counter_wdata_in), .compare_a_we_in(compare_a_we_in),
		.compare_b_we_in(compare_b_we_in), .compare_wdata_in(compare_wdata_in), .flag_we_in(flag_we_in),
		.flag_wdata_in(flag_wdata_in), .irq_ack_in(irq_ack_in), .mask_we_in(mask_we_in),
		.mask_wdata_in(mask_wdata_in), .counter_value_out(counter_value_out),
		.compare_value_a_out(compare_value_a_out), .compare_value_b_out(), .timer_flag_reg_out(timer_flag_reg_out),
		.timer_mask_reg_out(timer_mask_reg_out), .irq_req_out(irq_req_out), .waveform_mode_out(waveform_mode_out),
		.clock_source_select_out(clock_source_select_out), .action_a_out(), .action_b_out(),
		.waveform_out_a_out(waveform_out_a_out), .waveform_out_b_out(waveform_out_b_out),
		.match_a_out(match_a_out), .match_b_out(match_b_out), .at_top_out(), .at_bottom_out());

	// Clock and hang guard; the run needs well under a thousand cycles
	initial forever #20 mclk_in = ~mclk_in;
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			final_report();
		end
	end

	task automatic final_report();
		if (errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic step();
		@(negedge mclk_in);
	endtask

	// Control fields load together on one strobe
	task automatic wr_ctrl(input logic [2:0] m, input logic [2:0] cs, input logic [1:0] aa);
		step();
		{waveform_mode_high_in, waveform_mode_low_in} = m;
		clock_source_select_in = cs;
		action_a_in = aa;
		ctrl_we_in = 1'b1;
		step();
		ctrl_we_in = 1'b0;
	endtask

	// One-cycle software strobe of the given kind; data buses carry v
	task automatic sw(input int k, input logic [7:0] v);
		step();
		counter_wdata_in = v;
		compare_wdata_in = v;
		flag_wdata_in = v[2:0];
		mask_wdata_in = v[2:0];
		case (k)
			K_CNT: counter_we_in = 1'b1;
			K_CMPA: compare_a_we_in = 1'b1;
			K_CMPB: compare_b_we_in = 1'b1;
			K_FLAG: flag_we_in = 1'b1;
			K_MASK: mask_we_in = 1'b1;
			K_ACK: irq_ack_in = v[2:0];
			default: force_match_strobe_a_in = 1'b1;
		endcase
		step();
		{counter_we_in, compare_a_we_in, compare_b_we_in, flag_we_in, mask_we_in} = 5'h00;
		irq_ack_in = 3'h0;
		force_match_strobe_a_in = 1'b0;
	endtask

	task automatic t_reset();
		chk(counter_value_out, 8'h00, "counter");
		chk(compare_value_a_out, 8'h00, "compare a");
		chk({2'h0, timer_flag_reg_out, timer_mask_reg_out}, 8'h00, "flags and mask");
		chk({2'h0, clock_source_select_out, waveform_mode_out}, 8'h00, "controls");
		chk({6'h0, waveform_out_a_out, waveform_out_b_out}, 8'h00, "waveforms");
	endtask

	// Stopped timer: counter still writable, equal compare does not match
	task automatic t_stopped();
		sw(K_CMPA, 8'h10);
		chk(compare_value_a_out, 8'h10, "direct compare");
		sw(K_CNT, 8'h10);
		chk(counter_value_out, 8'h10, "counter write");
		repeat (3) step();
		chk(counter_value_out, 8'h10, "stopped counter");
		chk({7'h0, match_a_out}, 8'h00, "blocked match");
	endtask

	task automatic t_force();
		wr_ctrl(3'h0, 3'h0, 2'h1);
		sw(K_FLAG, 8'h07);
		sw(K_FORCE, 8'h00);
		step();
		chk({7'h0, waveform_out_a_out}, 8'h01, "forced toggle");
		chk({5'h0, timer_flag_reg_out}, 8'h00, "force sets no flag");
		wr_ctrl(3'h0, 3'h0, 2'h2);
		sw(K_FORCE, 8'h00);
		step();
		chk({7'h0, waveform_out_a_out}, 8'h00, "clear action");
		wr_ctrl(3'h0, 3'h0, 2'h3);
		sw(K_FORCE, 8'h00);
		step();
		chk({7'h0, waveform_out_a_out}, 8'h01, "set action");
		wr_ctrl(3'h3, 3'h0, 2'h0);
		chk({7'h0, waveform_out_a_out}, 8'h01, "waveform kept on mode change");
	endtask

	task automatic t_overflow();
		sw(K_MASK, 8'h01);
		wr_ctrl(3'h0, 3'h1, 2'h0);
		sw(K_CNT, 8'hfd);
		chk(counter_value_out, 8'hfd, "write beats count");
		for (int i = 0; i < 8 && counter_value_out !== 8'h00; i++)
			step();
		chk({7'h0, timer_flag_reg_out[0]}, 8'h01, "overflow flag");
		chk({7'h0, irq_req_out[0]}, 8'h01, "overflow request");
		sw(K_ACK, 8'h01);
		chk({7'h0, timer_flag_reg_out[0]}, 8'h00, "serviced flag");
	endtask

	task automatic t_match_b();
		wr_ctrl(3'h0, 3'h0, 2'h0);
		sw(K_CMPB, 8'h40);
		sw(K_CNT, 8'h3e);
		sw(K_FLAG, 8'h07);
		wr_ctrl(3'h0, 3'h1, 2'h0);
		for (int i = 0; i < 10 && counter_value_out !== 8'h42; i++) begin
			step();
			if (counter_value_out === 8'h40)
				chk({7'h0, match_b_out}, 8'h01, "match b");
		end
		chk({7'h0, timer_flag_reg_out[2]}, 8'h01, "match b flag");
		sw(K_FLAG, 8'h04);
		chk({7'h0, timer_flag_reg_out[2]}, 8'h00, "write one clears");
	endtask

	task automatic t_ctc();
		logic seen = 1'b0;
		wr_ctrl(3'h2, 3'h0, 2'h0);
		sw(K_CMPA, 8'h05);
		sw(K_CNT, 8'h00);
		wr_ctrl(3'h2, 3'h1, 2'h0);
		repeat (20) begin
			step();
			seen |= counter_value_out === 8'h05;
			chk({7'h0, counter_value_out > 8'h05}, 8'h00, "count above top");
		end
		chk({7'h0, seen}, 8'h01, "top reached");
	endtask

	// Fast PWM: new compare value waits in the buffer until top
	task automatic t_buffer();
		int hits = 0;
		logic [7:0] prev;
		wr_ctrl(3'h3, 3'h0, 2'h0);
		sw(K_CMPA, 8'h30);
		chk(compare_value_a_out, 8'h30, "buffered compare");
		sw(K_CNT, 8'h20);
		wr_ctrl(3'h3, 3'h1, 2'h0);
		for (int i = 0; i < 400 && hits < 2; i++) begin
			prev = counter_value_out;
			step();
			if (prev === 8'hff)
				chk(counter_value_out, 8'h00, "restart after top");
			if (counter_value_out === 8'h30) begin
				chk({7'h0, match_a_out}, {7'h0, hits == 1}, "load at top only");
				hits++;
			end
		end
		chk(hits[7:0], 8'h02, "two passes");
	endtask

	initial begin
		repeat (6) step();
		reset_in = 1'b0;
		step();
		t_reset();
		t_stopped();
		t_force();
		t_overflow();
		t_match_b();
		t_ctc();
		t_buffer();
		final_report();
	end
endmodule // tb_top
`default_nettype wire
